// ### thermal_cfg_pkg.sv
// constants, register map and carrier types for the pin role config block
package thermal_cfg_pkg;

  // register indices as numbered; byte address is four times the index
  localparam logic [7:0] IDX_PIN_ROLE = 8'h7D;
  localparam logic [7:0] IDX_TEST_ONE = 8'h7E;
  localparam logic [7:0] IDX_TEST_TWO = 8'h7F;
  localparam logic [7:0] IDX_TEST_THREE = 8'h80;

  localparam int ADDR_W = 10;
  localparam logic [9:0] ADDR_PIN_ROLE = {IDX_PIN_ROLE, 2'b00};
  localparam logic [9:0] ADDR_TEST_ONE = {IDX_TEST_ONE, 2'b00};
  localparam logic [9:0] ADDR_TEST_TWO = {IDX_TEST_TWO, 2'b00};
  localparam logic [9:0] ADDR_TEST_THREE = {IDX_TEST_THREE, 2'b00};

  // field positions of the pin role and thermal config register
  localparam int ROLE_LSB = 0;
  localparam int ROLE_MSB = 1;
  localparam int OFF_BIT = 2;
  localparam int SPEED_SEL_BIT = 3;
  localparam int SRC_SEL_BIT = 4;
  localparam int BYPASS_BIT = 5;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h3F;

  // reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] TEST_ONE_RESET = 8'h00;
  localparam logic [7:0] TEST_TWO_RESET = 8'h00;
  localparam logic [7:0] TEST_THREE_RESET = 8'h10;

  // fan and voltage constants
  localparam int FAN_CNT = 3;
  localparam logic [7:0] FULL_DUTY = 8'hFF;
  localparam logic [21:0] BYPASS_FULL_SCALE_UV = 22'h230AB4;
  localparam logic [21:0] ATTEN_FULL_SCALE_UV = 22'h2DC6C0;

  // shared pin roles
  typedef enum logic [1:0] {
    ROLE_TACH = 2'b00,
    ROLE_THERMAL_PIN = 2'b01,
    ROLE_ALERT = 2'b10,
    ROLE_GPIO = 2'b11
  } pin_role_t;

  // apb phase tracking, gray along idle, setup, access
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SETUP = 2'b01,
    PH_ACCESS = 2'b11
  } apb_phase_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [9:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

// ### factory_test_reg.sv
// read-only factory test register holding its power-on value
`timescale 1ns/10ps
module factory_test_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // stored value
  output logic [7:0] value_ff
);

  logic [7:0] nxt_value;

  // no write path: the value only ever holds
  always_comb begin
    nxt_value = value_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_ff <= RESET_VALUE;
    end else begin
      value_ff <= nxt_value;
    end
  end

endmodule

// ### apb_port.sv
// apb slave handshake: phase tracking, write strobe, registered read data
`timescale 1ns/10ps
module apb_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input thermal_cfg_pkg::apb_req_t req,
  output thermal_cfg_pkg::apb_rsp_t rsp,
  // decoded read data and error, valid during setup
  input wire logic [7:0] rd_data,
  input wire logic addr_err,
  // write strobe in the completing access cycle
  output logic wr_stb
);

  thermal_cfg_pkg::apb_phase_t phase_ff;
  thermal_cfg_pkg::apb_phase_t nxt_phase;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic err_ff;
  logic nxt_err;
  logic setup;
  logic access;

  assign setup = req.psel && !req.penable;
  assign access = req.psel && req.penable;

  // phase, read data and error captured at setup so prdata is a flop
  always_comb begin
    nxt_phase = phase_ff;
    nxt_rdata = rdata_ff;
    nxt_err = err_ff;
    if (setup) begin
      nxt_phase = thermal_cfg_pkg::PH_SETUP;
      nxt_rdata = rd_data;
      nxt_err = addr_err;
    end else if (access) begin
      nxt_phase = thermal_cfg_pkg::PH_ACCESS;
    end else begin
      nxt_phase = thermal_cfg_pkg::PH_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_ff <= thermal_cfg_pkg::PH_IDLE;
      rdata_ff <= 8'h00;
      err_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
    end
  end

  // zero wait states; a bare access without setup writes nothing
  assign wr_stb = access && req.pwrite && !err_ff &&
                  (phase_ff == thermal_cfg_pkg::PH_SETUP);
  assign rsp.pready = 1'b1;
  assign rsp.pslverr = access && err_ff;
  assign rsp.prdata = {24'h000000, rdata_ff};

endmodule

// ### pin_role_thermal_config.sv
// pin role and thermal config register bank with pin, fan and scale control
// How it works
// - bits 1:0 choose the shared pin: fan 4 tach, thermal, alert or gpio.
// - bit 2 set turns off every overtemperature output of the pin.
// - bit 3 clear sends all fans to full speed on a thermal limit trip.
// - bit 3 set sends each fan to its programmed maximum duty instead.
// - on the variant part bit 4 picks remote 2 alone or remotes 1 and 2.
// - bit 5 bypasses the core supply divider, full scale 2.2965 V.
// - with the lock bit set, writes to the config register are ignored.
// - the config register is all zeros after reset.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module pin_role_thermal_config #(
  parameter logic VARIANT_PART = 1'b1,
  parameter logic [21:0] ATTEN_FULL_SCALE_UV =
    thermal_cfg_pkg::ATTEN_FULL_SCALE_UV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input thermal_cfg_pkg::apb_req_t apb_req,
  output thermal_cfg_pkg::apb_rsp_t apb_rsp,
  // global lock bit held elsewhere
  input wire logic config_lock,
  // limit comparator results per temperature channel
  input wire logic local_over,
  input wire logic remote1_over,
  input wire logic remote2_over,
  // programmed maximum duties of the three outputs
  input wire logic [7:0] max_duty_0,
  input wire logic [7:0] max_duty_1,
  input wire logic [7:0] max_duty_2,
  // alert request and gpio controls from other logic
  input wire logic alert_request,
  input wire logic gpio_dir_out,
  input wire logic gpio_level,
  // shared pin, open-drain except in gpio output role
  input wire logic thermal_pin_i,
  output logic thermal_pin_o,
  output logic thermal_pin_oe,
  // pin role views
  output logic [1:0] shared_pin_role_select,
  output logic fan4_speed_input,
  output logic thermal_in_asserted,
  output logic gpio_in_level,
  // fan override
  output logic fan_override,
  output logic [7:0] fan_duty_0,
  output logic [7:0] fan_duty_1,
  output logic [7:0] fan_duty_2,
  // core supply channel scale
  output logic core_voltage_divider_bypass,
  output logic [21:0] core_full_scale_uv
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0] cfg_ff;
  logic [7:0] nxt_cfg;
  logic [7:0] test_one;
  logic [7:0] test_two;
  logic [7:0] test_three;
  logic wr_stb;
  logic cfg_hit;
  logic [7:0] rd_data;
  logic addr_err;

  thermal_cfg_pkg::pin_role_t role;
  logic thermal_output_off;
  logic overtemp_fan_speed_select;
  logic thermal_source_select;

  assign role = thermal_cfg_pkg::pin_role_t'(
    cfg_ff[thermal_cfg_pkg::ROLE_MSB:thermal_cfg_pkg::ROLE_LSB]);
  assign thermal_output_off = cfg_ff[thermal_cfg_pkg::OFF_BIT];
  assign overtemp_fan_speed_select = cfg_ff[thermal_cfg_pkg::SPEED_SEL_BIT];
  assign thermal_source_select = cfg_ff[thermal_cfg_pkg::SRC_SEL_BIT];

  factory_test_reg #(
    .RESET_VALUE(thermal_cfg_pkg::TEST_ONE_RESET)
  ) u_test_one (
    .clk(clk),
    .rst(rst),
    .value_ff(test_one)
  );

  factory_test_reg #(
    .RESET_VALUE(thermal_cfg_pkg::TEST_TWO_RESET)
  ) u_test_two (
    .clk(clk),
    .rst(rst),
    .value_ff(test_two)
  );

  // writes to the test registers complete but change nothing
  factory_test_reg #(
    .RESET_VALUE(thermal_cfg_pkg::TEST_THREE_RESET)
  ) u_test_three (
    .clk(clk),
    .rst(rst),
    .value_ff(test_three)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  apb_port u_apb (
    .clk(clk),
    .rst(rst),
    .req(apb_req),
    .rsp(apb_rsp),
    .rd_data(rd_data),
    .addr_err(addr_err),
    .wr_stb(wr_stb)
  );

  assign cfg_hit = (apb_req.paddr == thermal_cfg_pkg::ADDR_PIN_ROLE);

  // read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rd_data = 8'h00;
    addr_err = 1'b0;
    case (apb_req.paddr)
      thermal_cfg_pkg::ADDR_PIN_ROLE: begin
        rd_data = cfg_ff;
      end
      thermal_cfg_pkg::ADDR_TEST_ONE: begin
        rd_data = test_one;
      end
      thermal_cfg_pkg::ADDR_TEST_TWO: begin
        rd_data = test_two;
      end
      thermal_cfg_pkg::ADDR_TEST_THREE: begin
        rd_data = test_three;
      end
      default: begin
        addr_err = 1'b1;
      end
    endcase
  end

  // config write, dropped silently while locked, reserved bits masked
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_stb && cfg_hit && !config_lock) begin
      nxt_cfg = apb_req.pwdata[7:0] &
                thermal_cfg_pkg::CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= thermal_cfg_pkg::CFG_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared pin

  logic over_src;
  logic thermal_pin_drive;
  logic nxt_pin_o;
  logic nxt_pin_oe;
  logic nxt_fan4;
  logic nxt_thermal_pin_in;
  logic nxt_gpio_in;

  // base part has no source choice, so every channel counts there
  always_comb begin
    if (VARIANT_PART) begin
      over_src = thermal_source_select ? (remote1_over || remote2_over)
                                       : remote2_over;
    end else begin
      over_src = local_over || remote1_over || remote2_over;
    end
  end

  assign thermal_pin_drive = (role == thermal_cfg_pkg::ROLE_THERMAL_PIN) &&
                       !thermal_output_off && over_src;

  // pin drive per role; the thermal role reads the pin only when not driving it, the gpio role reads it even while driving
  always_comb begin
    nxt_pin_o = 1'b0;
    nxt_pin_oe = 1'b0;
    nxt_fan4 = 1'b0;
    nxt_thermal_pin_in = 1'b0;
    nxt_gpio_in = 1'b0;
    case (role)
      thermal_cfg_pkg::ROLE_TACH: begin
        nxt_fan4 = thermal_pin_i;
      end
      thermal_cfg_pkg::ROLE_THERMAL_PIN: begin
        nxt_pin_oe = thermal_pin_drive;
        nxt_thermal_pin_in = !thermal_pin_drive && !thermal_pin_i;
      end
      thermal_cfg_pkg::ROLE_ALERT: begin
        nxt_pin_oe = alert_request;
      end
      thermal_cfg_pkg::ROLE_GPIO: begin
        nxt_pin_o = gpio_level;
        nxt_pin_oe = gpio_dir_out;
        nxt_gpio_in = thermal_pin_i;
      end
      default: begin
        nxt_pin_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thermal_pin_o <= 1'b0;
      thermal_pin_oe <= 1'b0;
      fan4_speed_input <= 1'b0;
      thermal_in_asserted <= 1'b0;
      gpio_in_level <= 1'b0;
    end else begin
      thermal_pin_o <= nxt_pin_o;
      thermal_pin_oe <= nxt_pin_oe;
      fan4_speed_input <= nxt_fan4;
      thermal_in_asserted <= nxt_thermal_pin_in;
      gpio_in_level <= nxt_gpio_in;
    end
  end

  assign shared_pin_role_select = cfg_ff[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // fan override and supply scale

  logic limit_hit;
  logic nxt_override;
  logic [7:0] nxt_duty_0;
  logic [7:0] nxt_duty_1;
  logic [7:0] nxt_duty_2;
  logic [21:0] nxt_scale;

  // fans respond even when the pin output is turned off
  assign limit_hit = local_over || remote1_over || remote2_over;

  always_comb begin
    nxt_override = limit_hit;
    nxt_duty_0 = 8'h00;
    nxt_duty_1 = 8'h00;
    nxt_duty_2 = 8'h00;
    if (limit_hit && overtemp_fan_speed_select) begin
      nxt_duty_0 = max_duty_0;
      nxt_duty_1 = max_duty_1;
      nxt_duty_2 = max_duty_2;
    end else if (limit_hit) begin
      nxt_duty_0 = thermal_cfg_pkg::FULL_DUTY;
      nxt_duty_1 = thermal_cfg_pkg::FULL_DUTY;
      nxt_duty_2 = thermal_cfg_pkg::FULL_DUTY;
    end
    nxt_scale = cfg_ff[thermal_cfg_pkg::BYPASS_BIT] ?
                thermal_cfg_pkg::BYPASS_FULL_SCALE_UV :
                ATTEN_FULL_SCALE_UV;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fan_override <= 1'b0;
      fan_duty_0 <= 8'h00;
      fan_duty_1 <= 8'h00;
      fan_duty_2 <= 8'h00;
      core_full_scale_uv <= ATTEN_FULL_SCALE_UV;
    end else begin
      fan_override <= nxt_override;
      fan_duty_0 <= nxt_duty_0;
      fan_duty_1 <= nxt_duty_1;
      fan_duty_2 <= nxt_duty_2;
      core_full_scale_uv <= nxt_scale;
    end
  end

  assign core_voltage_divider_bypass = cfg_ff[thermal_cfg_pkg::BYPASS_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  tach_role_a: assert property (
    role == thermal_cfg_pkg::ROLE_TACH |=>
      !thermal_pin_oe && fan4_speed_input == $past(thermal_pin_i))
    else $error("tach role drives pin or drops tach");

  alert_role_a: assert property (
    role == thermal_cfg_pkg::ROLE_ALERT |=>
      thermal_pin_oe == $past(alert_request) && !thermal_pin_o)
    else $error("alert role pin drive wrong");

  thermal_pin_in_a: assert property (
    role == thermal_cfg_pkg::ROLE_THERMAL_PIN |=> thermal_in_asserted ==
      (!$past(thermal_pin_drive) && !$past(thermal_pin_i)))
    else $error("thermal input view wrong");

  thermal_pin_off_a: assert property (
    thermal_output_off && $stable(cfg_ff) |=> !thermal_pin_oe ||
      $past(role) != thermal_cfg_pkg::ROLE_THERMAL_PIN)
    else $error("thermal output active while turned off");

  full_speed_a: assert property (
    limit_hit && !overtemp_fan_speed_select |=>
      fan_override && fan_duty_0 == 8'hFF && fan_duty_1 == 8'hFF &&
      fan_duty_2 == 8'hFF)
    else $error("fans not at full speed on limit");

  max_speed_a: assert property (
    limit_hit && overtemp_fan_speed_select |=>
      fan_duty_0 == $past(max_duty_0) && fan_duty_2 == $past(max_duty_2))
    else $error("fans not at programmed maximum on limit");

  source_pick_a: assert property (
    VARIANT_PART && role == thermal_cfg_pkg::ROLE_THERMAL_PIN &&
    !thermal_output_off && remote1_over && !remote2_over |=>
      thermal_pin_oe == $past(thermal_source_select))
    else $error("wrong thermal source selection");

  bypass_scale_a: assert property (
    core_voltage_divider_bypass ##1 core_voltage_divider_bypass |->
      core_full_scale_uv == thermal_cfg_pkg::BYPASS_FULL_SCALE_UV)
    else $error("bypass full scale wrong");

  lock_hold_a: assert property (
    wr_stb && cfg_hit && config_lock |=> $stable(cfg_ff))
    else $error("locked config register changed");

  write_take_a: assert property (
    wr_stb && cfg_hit && !config_lock |=>
      cfg_ff == ($past(apb_req.pwdata[7:0]) & 8'h3F))
    else $error("unlocked write not taken");

  reset_zero_a: assert property (
    $past(rst) |-> cfg_ff == 8'h00)
    else $error("config not zero after reset");

  test_const_a: assert property (
    test_one == 8'h00 && test_two == 8'h00 && test_three == 8'h10)
    else $error("factory test register changed");

  reserved_zero_a: assert property (
    cfg_ff[7:6] == 2'b00)
    else $error("reserved config bits set");

endmodule

// ### pin_role_thermal_config_tb_top.sv
// self-checking bench for the pin role and thermal config register bank
`timescale 1ns/10ps
module pin_role_thermal_config_tb_top;
  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  thermal_cfg_pkg::apb_req_t apb_req = '0;
  thermal_cfg_pkg::apb_rsp_t apb_rsp;
  logic config_lock = 1'b0;
  logic local_over = 1'b0;
  logic remote1_over = 1'b0;
  logic remote2_over = 1'b0;
  logic [7:0] max_duty_0 = 8'h11;
  logic [7:0] max_duty_1 = 8'h22;
  logic [7:0] max_duty_2 = 8'h33;
  logic alert_request = 1'b0;
  logic gpio_dir_out = 1'b0;
  logic gpio_level = 1'b0;
  logic ext_level = 1'b1;
  logic thermal_pin_o, thermal_pin_oe, fan4_speed_input;
  logic thermal_in_asserted, gpio_in_level, fan_override;
  logic core_voltage_divider_bypass;
  logic [1:0] shared_pin_role_select;
  logic [7:0] fan_duty_0, fan_duty_1, fan_duty_2;
  logic [21:0] core_full_scale_uv;
  wire logic pin_level;
  int fail_count = 0;
  int n_tests = 0;
  localparam logic [9:0] A_CFG = thermal_cfg_pkg::ADDR_PIN_ROLE;
  localparam logic [31:0] ATTEN_UV =
    32'(thermal_cfg_pkg::ATTEN_FULL_SCALE_UV);
  localparam logic [31:0] BYPASS_UV =
    32'(thermal_cfg_pkg::BYPASS_FULL_SCALE_UV);

  // wire level: pull-up unless someone drives it
  assign pin_level = thermal_pin_oe ? thermal_pin_o : ext_level;

  // free-running 100 MHz clock
  always #5 clk = ~clk;

  pin_role_thermal_config #(.VARIANT_PART(1'b1)) dut_u (
    .clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .config_lock(config_lock), .local_over(local_over),
    .remote1_over(remote1_over), .remote2_over(remote2_over),
    .max_duty_0(max_duty_0), .max_duty_1(max_duty_1),
    .max_duty_2(max_duty_2), .alert_request(alert_request),
    .gpio_dir_out(gpio_dir_out), .gpio_level(gpio_level),
    .thermal_pin_i(pin_level), .thermal_pin_o(thermal_pin_o),
    .thermal_pin_oe(thermal_pin_oe),
    .shared_pin_role_select(shared_pin_role_select),
    .fan4_speed_input(fan4_speed_input),
    .thermal_in_asserted(thermal_in_asserted),
    .gpio_in_level(gpio_in_level), .fan_override(fan_override),
    .fan_duty_0(fan_duty_0), .fan_duty_1(fan_duty_1),
    .fan_duty_2(fan_duty_2),
    .core_voltage_divider_bypass(core_voltage_divider_bypass),
    .core_full_scale_uv(core_full_scale_uv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits on pready, never assumes its timing
  task automatic apb(input logic w, input logic [9:0] a,
    input logic [7:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= w;
    apb_req.paddr <= a;
    apb_req.pwdata <= {24'h000000, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, exp);
  endtask

  // let registered outputs catch up, then step off the edge
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd(A_CFG, 32'h00000000);
    rd(thermal_cfg_pkg::ADDR_TEST_ONE, 32'h00000000);
    rd(thermal_cfg_pkg::ADDR_TEST_TWO, 32'h00000000);
    rd(thermal_cfg_pkg::ADDR_TEST_THREE, 32'h00000010);
    chk(32'(core_full_scale_uv), ATTEN_UV);
    $display("test reset done");
  endtask

  task automatic t_reserved_bypass();
    wr(A_CFG, 8'hFF);
    rd(A_CFG, 32'h0000003F);
    settle();
    chk(32'(core_voltage_divider_bypass), 32'h00000001);
    chk(32'(core_full_scale_uv), BYPASS_UV);
    wr(A_CFG, 8'h00);
    settle();
    chk(32'(core_voltage_divider_bypass), 32'h00000000);
    $display("test reserved and bypass done");
  endtask

  task automatic t_roles();
    for (int r = 0; r < 4; r++) begin
      wr(A_CFG, 8'(r));
      settle();
      chk(32'(shared_pin_role_select), 32'(r));
    end
    // gpio input role follows the wire
    chk(32'(gpio_in_level), 32'h00000001);
    @(posedge clk);
    ext_level <= 1'b0;
    settle();
    chk(32'(gpio_in_level), 32'h00000000);
    // gpio output role drives the wire push-pull
    @(posedge clk);
    gpio_dir_out <= 1'b1;
    gpio_level <= 1'b1;
    settle();
    chk(32'({thermal_pin_oe, thermal_pin_o}), 32'h00000003);
    chk(32'(gpio_in_level), 32'h00000001);
    @(posedge clk);
    gpio_level <= 1'b0;
    settle();
    chk(32'({thermal_pin_oe, thermal_pin_o}), 32'h00000002);
    chk(32'(gpio_in_level), 32'h00000000);
    @(posedge clk);
    gpio_dir_out <= 1'b0;
    wr(A_CFG, 8'h02);
    alert_request <= 1'b1;
    settle();
    chk(32'({thermal_pin_oe, thermal_pin_o}), 32'h00000002);
    @(posedge clk);
    alert_request <= 1'b0;
    wr(A_CFG, 8'h00);
    settle();
    chk(32'(fan4_speed_input), 32'h00000000);
    @(posedge clk);
    ext_level <= 1'b1;
    settle();
    chk(32'(fan4_speed_input), 32'h00000001);
    $display("test pin roles done");
  endtask

  task automatic t_fans();
    @(posedge clk);
    local_over <= 1'b1;
    settle();
    chk(32'(fan_override), 32'h00000001);
    chk(32'({fan_duty_0, fan_duty_1, fan_duty_2}), 32'h00FFFFFF);
    wr(A_CFG, 8'h08);
    settle();
    chk(32'({fan_duty_0, fan_duty_1, fan_duty_2}), 32'h00112233);
    @(posedge clk);
    local_over <= 1'b0;
    settle();
    chk(32'({fan_override, fan_duty_0}), 32'h00000000);
    $display("test fan override done");
  endtask

  task automatic t_thermal();
    wr(A_CFG, 8'h01);
    ext_level <= 1'b0;
    settle();
    chk(32'(thermal_in_asserted), 32'h00000001);
    @(posedge clk);
    ext_level <= 1'b1;
    remote2_over <= 1'b1;
    settle();
    chk(32'({thermal_pin_oe, thermal_pin_o}), 32'h00000002);
    chk(32'(thermal_in_asserted), 32'h00000000);
    wr(A_CFG, 8'h05);
    settle();
    chk(32'(thermal_pin_oe), 32'h00000000);
    @(posedge clk);
    remote2_over <= 1'b0;
    remote1_over <= 1'b1;
    wr(A_CFG, 8'h01);
    settle();
    chk(32'(thermal_pin_oe), 32'h00000000);
    wr(A_CFG, 8'h11);
    settle();
    chk(32'(thermal_pin_oe), 32'h00000001);
    @(posedge clk);
    remote1_over <= 1'b0;
    $display("test thermal output done");
  endtask

  task automatic t_lock();
    wr(A_CFG, 8'h21);
    config_lock <= 1'b1;
    wr(A_CFG, 8'h02);
    rd(A_CFG, 32'h00000021);
    settle();
    chk(32'(shared_pin_role_select), 32'h00000001);
    @(posedge clk);
    config_lock <= 1'b0;
    wr(A_CFG, 8'h00);
    rd(A_CFG, 32'h00000000);
    $display("test lock done");
  endtask

  task automatic t_test_regs();
    logic [31:0] r;
    logic e;
    wr(thermal_cfg_pkg::ADDR_TEST_ONE, 8'hAA);
    wr(thermal_cfg_pkg::ADDR_TEST_THREE, 8'h55);
    rd(thermal_cfg_pkg::ADDR_TEST_ONE, 32'h00000000);
    rd(thermal_cfg_pkg::ADDR_TEST_THREE, 32'h00000010);
    // unmapped word answers with an error and zero data
    apb(1'b0, 10'h004, 8'h00, r, e);
    chk({r[30:0], e}, 32'h00000001);
    $display("test factory registers done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict, main sequence and watchdog
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_reserved_bypass();
    t_roles();
    t_fans();
    t_thermal();
    t_lock();
    t_test_regs();
    print_verdict();
  end

  // the whole run needs well under 1000 cycles
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
endmodule
